// File: src/ldp_pkg.sv
// Package for the LED dimming PWM control block.
// Assumes a 100 MHz system clock standing in for the 20 MHz oscillator.
package ldp_pkg;
    // Clocking
    localparam int CLK_HZ = 100_000_000;
    localparam int OSC_HZ = 20_000_000;
    localparam int TICK_DIV = CLK_HZ / OSC_HZ;
    localparam logic [2:0] TICK_LAST = 3'(TICK_DIV - 1);
    // Widths
    localparam int NUM_CH = 6;
    localparam int CODE_W = 12;
    localparam int BRT_W = 16;
    localparam int CNT_W = 17;
    localparam int STRAP_W = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int I2C_AW = 7;
    localparam int MEAS_W = 24;
    localparam logic [2:0] CH_LAST = 3'(NUM_CH - 1);
    localparam logic [CODE_W-1:0] CODE_FULL = 12'hFFF;
    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_CURRENT_LAST = 8'h05;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_BRT = 8'h11;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h12;
    localparam logic [ADDR_W-1:0] ADDR_DUTY = 8'h13;
    // Control fields
    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_HYB0_BIT = 1;
    localparam int CTRL_SLOPE_LSB = 2;
    localparam int SLOPE_W = 3;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0004;
    localparam logic [DATA_W-1:0] BRT_RESET = 16'h0000;
    // Brightness arithmetic, fractions of 2^16
    localparam logic [BRT_W-1:0] BRT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] FRAC_FULL = 17'h10000;
    localparam logic [BRT_W-1:0] HYB_THRESH = 16'h2000;
    localparam int HYB_GAIN_SHIFT = 3;
    localparam logic [BRT_W-1:0] SLOPE_BASE_STEP = 16'h0400;
    localparam logic [4:0] PER_SHIFT_BASE = 5'd17;
    localparam logic [MEAS_W-1:0] PER_MAX = 24'hFFFFFF;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    // Serial target addresses
    localparam logic [I2C_AW-1:0] I2C_ADDR_LOW = 7'h2B;
    localparam logic [I2C_AW-1:0] I2C_ADDR_HIGH = 7'h2A;
    // Phase step per slot, as a fraction of a turn, indexed by slot count
    localparam logic [BRT_W-1:0] SLOT_FRAC [8] = '{16'h0000, 16'h0000,
        16'h8000, 16'h5555, 16'h4000, 16'h3333, 16'h2AAB, 16'h0000};

    typedef enum logic [1:0] {DM_PHASE, DM_HYBRID, DM_CURRENT, DM_DIRECT}
        ldp_mode_t;

    // Strap codes 0..4 ungrouped 6..2 strings, 5..7 grouped 3, 2, 1
    function automatic logic [2:0] slot_count(input logic [2:0] cfg);
        case (cfg)
            3'h0: slot_count = 3'h6;
            3'h1: slot_count = 3'h5;
            3'h2: slot_count = 3'h4;
            3'h3, 3'h5: slot_count = 3'h3;
            3'h4, 3'h6: slot_count = 3'h2;
            default: slot_count = 3'h1;
        endcase
    endfunction

    function automatic logic [2:0] chan_slot(input logic [2:0] cfg,
                                             input logic [2:0] ch);
        case (cfg)
            3'h5: chan_slot = ch >> 1;
            3'h6: chan_slot = (ch >= 3'h3) ? 3'h1 : 3'h0;
            3'h7: chan_slot = 3'h0;
            default: chan_slot = ch;
        endcase
    endfunction

    // Fraction of 2^16 scaled to a count of 2^shift
    function automatic logic [CNT_W:0] to_count(input logic [CNT_W-1:0] frac,
                                                input logic [4:0] shift);
        logic [33:0] t;
        t = 34'(frac) << shift;
        to_count = t[33:16];
    endfunction

    function automatic logic [CNT_W-1:0] brt_frac(input logic [BRT_W-1:0] b);
        brt_frac = (b == BRT_MAX) ? FRAC_FULL : {1'b0, b};
    endfunction
endpackage

// File: src/ldp_mem_if.sv
// Interface between the dimming controller and its current-code store.
// Assumes both ends share clk.
`timescale 1ns/10ps
interface ldp_mem_if
    import ldp_pkg::*;
;
    logic wr_en;
    logic [2:0] wr_addr;
    logic [CODE_W-1:0] wr_data;
    logic [2:0] rd_addr_a;
    logic [2:0] rd_addr_b;
    logic [CODE_W-1:0] rd_data_a;
    logic [CODE_W-1:0] rd_data_b;
    modport ctrl (output wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
                  input rd_data_a, rd_data_b);
    modport mem (input wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
                 output rd_data_a, rd_data_b);
endinterface

// File: src/ldp_code_mem.sv
// Per-string current code store, one write and two registered read ports.
// Assumes the controller keeps addresses in range; others read zero.
`timescale 1ns/10ps
module ldp_code_mem
    import ldp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Access
    ldp_mem_if.mem port
);
    logic [CODE_W-1:0] codes [NUM_CH];
    logic [CODE_W-1:0] next_codes [NUM_CH];
    logic [CODE_W-1:0] next_rd_a;
    logic [CODE_W-1:0] next_rd_b;

    always_comb begin
        next_codes = codes;
        if (port.wr_en && port.wr_addr <= CH_LAST) begin
            next_codes[port.wr_addr] = port.wr_data;
        end
        next_rd_a = (port.rd_addr_a <= CH_LAST) ? codes[port.rd_addr_a] : '0;
        next_rd_b = (port.rd_addr_b <= CH_LAST) ? codes[port.rd_addr_b] : '0;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                codes[i] <= CODE_FULL;
            end
            port.rd_data_a <= '0;
            port.rd_data_b <= '0;
        end else begin
            codes <= next_codes;
            port.rd_data_a <= next_rd_a;
            port.rd_data_b <= next_rd_b;
        end
    end
endmodule // ldp_code_mem

// File: src/ldp_dimming_ctrl.sv
// LED dimming control: brightness source, sloper, phase-shifted PWM and
// per-string current levels for six sinks. Assumes straps are stable
// while powered and the register port is driven in the clk domain.
// Notes on behaviour
// - Each string has a 12-bit current code, reset to 0xFFF, scaling current by code/4095.
// - Ungrouped strings are spaced 60, 72, 90, 120 or 180 degrees for six to two strings.
// - Grouped strings run as three pairs 120 degrees apart, two triples 180 apart or one group.
// - The string strap is caught once after reset and fixes every channel's phase slot.
// - Outside direct mode, LED PWM runs from the 20 MHz oscillator, free of the input PWM timing.
// - The frequency strap picks 152 Hz up to 19531 Hz in eight binary steps.
// - Undithered resolution is 16, 16, 15, 14, 13, 12, 11 and 10 bits from low to high rate.
// - A source bit picks measured input duty or the brightness register, input by default.
// - A sloper, enabled after reset and set by register, smooths brightness changes.
// - The mode strap picks phase-shift, hybrid, current or direct dimming and the address.
// - In phase-shift mode each slot switches at the LED rate, delayed by a fixed step.
// - Hybrid mode uses PWM below 12.5 percent or 0 percent and current above it.
// - Hybrid mode adds a factor of 8 of dimming range by scaling current with PWM.
// - Direct mode makes active channels follow the input PWM pin.
// - Steps per PWM period equal the oscillator rate over the LED PWM rate.
`timescale 1ns/10ps
module ldp_dimming_ctrl
    import ldp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Pins and straps
    input wire logic pwm_in,
    input wire logic [STRAP_W-1:0] string_config_strap,
    input wire logic [STRAP_W-1:0] pwm_frequency_strap,
    input wire logic [STRAP_W-1:0] mode_strap,
    // Register port behind the serial target
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // LED sinks and status
    output logic [NUM_CH-1:0] led_pwm_out,
    output logic [NUM_CH-1:0][CODE_W-1:0] led_current_level,
    output logic [I2C_AW-1:0] i2c_address,
    output logic straps_ready
);
    ldp_mem_if mem_if ();
    ldp_code_mem u_mem (.clk(clk), .sys_rst(sys_rst), .port(mem_if.mem));

    // Pin synchronisers
    logic pwm_meta, pwm_sync, pwm_prev;
    logic [3*STRAP_W-1:0] strap_meta, strap_sync;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_meta <= 1'b0;
            pwm_sync <= 1'b0;
            pwm_prev <= 1'b0;
            strap_meta <= '0;
            strap_sync <= '0;
        end else begin
            pwm_meta <= pwm_in;
            pwm_sync <= pwm_meta;
            pwm_prev <= pwm_sync;
            strap_meta <= {mode_strap, pwm_frequency_strap,
                           string_config_strap};
            strap_sync <= strap_meta;
        end
    end

    // Strap capture, once per reset
    logic [1:0] strap_wait, next_strap_wait;
    logic [2:0] cfg, fsel, mstrap, next_cfg, next_fsel, next_mstrap;
    logic next_straps_ready;
    always_comb begin
        next_strap_wait = strap_wait;
        next_cfg = cfg;
        next_fsel = fsel;
        next_mstrap = mstrap;
        next_straps_ready = straps_ready;
        if (!straps_ready) begin
            if (strap_wait == STRAP_SETTLE) begin
                // Later strap moves are ignored until the next reset
                {next_mstrap, next_fsel, next_cfg} = strap_sync;
                next_straps_ready = 1'b1;
            end else begin
                next_strap_wait = strap_wait + 2'h1;
            end
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_wait <= '0;
            cfg <= '0;
            fsel <= '0;
            mstrap <= '0;
            straps_ready <= 1'b0;
        end else begin
            strap_wait <= next_strap_wait;
            cfg <= next_cfg;
            fsel <= next_fsel;
            mstrap <= next_mstrap;
            straps_ready <= next_straps_ready;
        end
    end

    ldp_mode_t dmode;
    logic [4:0] shift;
    logic [CNT_W-1:0] mask;
    logic [NUM_CH-1:0] active_mask;
    always_comb begin
        case (mstrap[1:0])
            2'h0: dmode = DM_PHASE;
            2'h1: dmode = DM_HYBRID;
            2'h2: dmode = DM_CURRENT;
            default: dmode = DM_DIRECT;
        endcase
        i2c_address = mstrap[2] ? I2C_ADDR_HIGH : I2C_ADDR_LOW;
        shift = PER_SHIFT_BASE - {2'h0, fsel};
        mask = CNT_W'((18'h1 << shift) - 18'h1);
        for (int c = 0; c < NUM_CH; c++) begin
            active_mask[c] = (cfg > 3'h4) || (3'(c) < slot_count(cfg));
        end
    end

    // Registers
    logic [DATA_W-1:0] ctrl, brt_reg, rdata_q, meas_duty;
    logic [DATA_W-1:0] next_ctrl, next_brt_reg, next_rdata_q;
    logic rd_mem_q, next_rd_mem_q, next_rvalid;
    logic addr_is_code;
    assign addr_is_code = (reg_addr <= ADDR_CURRENT_LAST);
    assign mem_if.wr_en = reg_wr && addr_is_code;
    assign mem_if.wr_addr = reg_addr[2:0];
    assign mem_if.wr_data = reg_wdata[CODE_W-1:0];
    assign mem_if.rd_addr_a = reg_addr[2:0];
    assign reg_rdata = rd_mem_q ? DATA_W'(mem_if.rd_data_a) : rdata_q;
    always_comb begin
        next_ctrl = ctrl;
        next_brt_reg = brt_reg;
        next_rdata_q = rdata_q;
        next_rd_mem_q = 1'b0;
        next_rvalid = reg_rd;
        if (reg_wr && reg_addr == ADDR_CTRL) next_ctrl = reg_wdata;
        if (reg_wr && reg_addr == ADDR_BRT) next_brt_reg = reg_wdata;
        if (reg_rd) begin
            next_rd_mem_q = addr_is_code;
            case (reg_addr)
                ADDR_CTRL: next_rdata_q = ctrl;
                ADDR_BRT: next_rdata_q = brt_reg;
                ADDR_STATUS: next_rdata_q = {6'h00, straps_ready, mstrap,
                                             fsel, cfg};
                ADDR_DUTY: next_rdata_q = meas_duty;
                default: next_rdata_q = '0;
            endcase
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= CTRL_RESET;
            brt_reg <= BRT_RESET;
            rdata_q <= '0;
            rd_mem_q <= 1'b0;
            reg_rvalid <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            brt_reg <= next_brt_reg;
            rdata_q <= next_rdata_q;
            rd_mem_q <= next_rd_mem_q;
            reg_rvalid <= next_rvalid;
        end
    end

    // Input duty measurement; serial divide keeps area small
    logic [MEAS_W-1:0] per_cnt, hi_cnt, den, next_per_cnt, next_hi_cnt;
    logic [MEAS_W-1:0] next_den;
    logic [MEAS_W:0] rem, next_rem, trial;
    logic [BRT_W-1:0] quot, next_quot, next_meas_duty;
    logic [3:0] div_cnt, next_div_cnt;
    logic div_busy, next_div_busy, pwm_rise;
    assign pwm_rise = pwm_sync && !pwm_prev;
    always_comb begin
        next_per_cnt = (per_cnt == PER_MAX) ? per_cnt : per_cnt + 24'h1;
        next_hi_cnt = (pwm_sync && per_cnt != PER_MAX) ? hi_cnt + 24'h1
                                                       : hi_cnt;
        next_rem = rem;
        next_den = den;
        next_quot = quot;
        next_div_cnt = div_cnt;
        next_div_busy = div_busy;
        next_meas_duty = meas_duty;
        trial = {rem[MEAS_W-1:0], 1'b0};
        if (per_cnt == PER_MAX) begin
            next_meas_duty = pwm_sync ? BRT_MAX : '0;
        end
        if (div_busy) begin
            if (trial >= {1'b0, den}) begin
                next_rem = trial - {1'b0, den};
                next_quot = {quot[BRT_W-2:0], 1'b1};
            end else begin
                next_rem = trial;
                next_quot = {quot[BRT_W-2:0], 1'b0};
            end
            next_div_cnt = div_cnt + 4'h1;
            if (div_cnt == 4'(BRT_W - 1)) begin
                next_div_busy = 1'b0;
                next_meas_duty = next_quot;
            end
        end
        if (pwm_rise) begin
            next_per_cnt = 24'h1;
            next_hi_cnt = 24'h1;
            if (per_cnt != PER_MAX) begin
                next_rem = {1'b0, hi_cnt};
                next_den = per_cnt;
                next_quot = '0;
                next_div_cnt = '0;
                next_div_busy = 1'b1;
            end
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            per_cnt <= PER_MAX;
            hi_cnt <= '0;
            rem <= '0;
            den <= '0;
            quot <= '0;
            div_cnt <= '0;
            div_busy <= 1'b0;
            meas_duty <= '0;
        end else begin
            per_cnt <= next_per_cnt;
            hi_cnt <= next_hi_cnt;
            rem <= next_rem;
            den <= next_den;
            quot <= next_quot;
            div_cnt <= next_div_cnt;
            div_busy <= next_div_busy;
            meas_duty <= next_meas_duty;
        end
    end

    // Oscillator tick and sloper
    logic [2:0] tick_cnt, next_tick_cnt;
    logic [BRT_W-1:0] slope_brt, next_slope_brt, target, step;
    logic [SLOPE_W-1:0] slope_sel;
    logic tick;
    assign tick = (tick_cnt == TICK_LAST);
    assign slope_sel = ctrl[CTRL_SLOPE_LSB +: SLOPE_W];
    assign target = ctrl[CTRL_SRC_BIT] ? brt_reg : meas_duty;
    assign step = SLOPE_BASE_STEP >> slope_sel;
    always_comb begin
        next_tick_cnt = tick ? '0 : tick_cnt + 3'h1;
        next_slope_brt = slope_brt;
        if (tick) begin
            if (slope_sel == '0) begin
                next_slope_brt = target;
            end else if (slope_brt < target) begin
                next_slope_brt = (target - slope_brt > step)
                               ? slope_brt + step : target;
            end else if (slope_brt > target) begin
                next_slope_brt = (slope_brt - target > step)
                               ? slope_brt - step : target;
            end
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt <= '0;
            slope_brt <= '0;
        end else begin
            tick_cnt <= next_tick_cnt;
            slope_brt <= next_slope_brt;
        end
    end

    // Split of brightness between pulse width and current
    logic [CNT_W-1:0] pwm_frac, cur_frac;
    always_comb begin
        case (dmode)
            DM_PHASE: begin
                pwm_frac = brt_frac(slope_brt);
                cur_frac = FRAC_FULL;
            end
            DM_HYBRID: begin
                // Below threshold current stays at 1/8 and PWM gains 8
                if (!ctrl[CTRL_HYB0_BIT] && slope_brt < HYB_THRESH) begin
                    pwm_frac = {1'b0, slope_brt} << HYB_GAIN_SHIFT;
                    cur_frac = {1'b0, HYB_THRESH};
                end else begin
                    pwm_frac = FRAC_FULL;
                    cur_frac = brt_frac(slope_brt);
                end
            end
            DM_CURRENT: begin
                pwm_frac = FRAC_FULL;
                cur_frac = brt_frac(slope_brt);
            end
            default: begin
                pwm_frac = FRAC_FULL;
                cur_frac = FRAC_FULL;
            end
        endcase
    end

    // PWM counter, outputs and current scan
    logic [CNT_W-1:0] pwm_cnt, next_pwm_cnt, pos, off;
    logic [CNT_W:0] duty;
    logic [NUM_CH-1:0] next_led;
    logic [2:0] scan_idx, scan_idx_d, next_scan_idx;
    logic [NUM_CH-1:0][CODE_W-1:0] next_level;
    logic [CODE_W+CNT_W-1:0] prod;
    assign mem_if.rd_addr_b = scan_idx;
    assign duty = to_count(pwm_frac, shift);
    always_comb begin
        next_pwm_cnt = tick ? (pwm_cnt + 17'h1) & mask : pwm_cnt;
        pos = '0;
        off = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            off = CNT_W'(to_count({1'b0, 16'(chan_slot(cfg, 3'(c))
                  * SLOT_FRAC[slot_count(cfg)])}, shift));
            pos = (pwm_cnt - off) & mask;
            if (dmode == DM_DIRECT) begin
                next_led[c] = straps_ready && active_mask[c]
                              && pwm_sync;
            end else begin
                next_led[c] = straps_ready && active_mask[c]
                              && ({1'b0, pos} < duty);
            end
        end
        next_scan_idx = (scan_idx == CH_LAST) ? '0 : scan_idx + 3'h1;
        next_level = led_current_level;
        prod = (CODE_W + CNT_W)'(mem_if.rd_data_b) * cur_frac;
        next_level[scan_idx_d] = prod[CODE_W+BRT_W-1:BRT_W];
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_cnt <= '0;
            led_pwm_out <= '0;
            scan_idx <= '0;
            scan_idx_d <= '0;
            led_current_level <= '0;
        end else begin
            pwm_cnt <= next_pwm_cnt;
            led_pwm_out <= next_led;
            scan_idx <= next_scan_idx;
            scan_idx_d <= scan_idx;
            led_current_level <= next_level;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence tick_gap_s;
        !tick [*4] ##1 tick;
    endsequence
    osc_tick_period_a: assert property (tick |=> tick_gap_s)
        else $error("oscillator tick not every five clocks");
    pwm_wrap_a: assert property (tick && pwm_cnt == mask
        |=> pwm_cnt == '0)
        else $error("pwm counter did not wrap");
    duty_bound_a: assert property (duty <= {1'b0, mask} + 18'h1)
        else $error("duty beyond period");
    unused_off_a: assert property ((led_pwm_out & ~active_mask) == '0)
        else $error("unused channel switched");
    one_group_a: assert property (straps_ready && cfg == 3'h7
        |-> led_pwm_out == '0 || led_pwm_out == '1)
        else $error("single group channels differ");
    strap_hold_a: assert property (straps_ready |=> $stable(cfg)
        && $stable(fsel) && $stable(mstrap))
        else $error("strap changed after capture");
    direct_follow_a: assert property (straps_ready && dmode == DM_DIRECT
        |=> led_pwm_out == ($past(pwm_sync) ? active_mask : '0))
        else $error("direct mode not following input");
    sloper_bypass_a: assert property (tick && slope_sel == '0
        |=> slope_brt == $past(target))
        else $error("bypassed sloper not tracking");
    // A bypassed sloper would jump by the whole change in one tick
    slope_rate_a: assert property (tick && slope_sel != '0
        |=> (slope_brt > $past(slope_brt) ? slope_brt - $past(slope_brt)
        : $past(slope_brt) - slope_brt) <= $past(step))
        else $error("sloper moved more than one step");
    hybrid_low_a: assert property (dmode == DM_HYBRID
        && !ctrl[CTRL_HYB0_BIT] && slope_brt < HYB_THRESH
        |-> pwm_frac == CNT_W'({1'b0, slope_brt} << HYB_GAIN_SHIFT)
        && cur_frac == {1'b0, HYB_THRESH})
        else $error("hybrid low split wrong");
    code_pass_a: assert property (dmode == DM_PHASE
        |=> led_current_level[$past(scan_idx_d)] == $past(mem_if.rd_data_b))
        else $error("phase mode current not equal to code");
endmodule // ldp_dimming_ctrl

// File: verification/ldp_led_strings.sv
// LED string model: logs when each sink turns on and off.
// Assumes the sink enables change only after clk rising edges.
`timescale 1ns/10ps
module ldp_led_strings
    import ldp_pkg::*;
(
    // Clock
    input wire logic clk,
    // Sinks
    input wire logic [NUM_CH-1:0] led_pwm_out,
    // Edge times, in clk cycles
    output logic [31:0] rise_t [NUM_CH],
    output logic [31:0] fall_t [NUM_CH]
);
    logic [31:0] now = 32'h0;
    logic [NUM_CH-1:0] last = '0;
    always @(posedge clk) begin
        now <= now + 32'h1;
        last <= led_pwm_out;
        for (int c = 0; c < NUM_CH; c++) begin
            if (led_pwm_out[c] && !last[c]) rise_t[c] <= now;
            if (!led_pwm_out[c] && last[c]) fall_t[c] <= now;
        end
    end
endmodule // ldp_led_strings

// File: verification/led_dimming_pwm_control_bench.sv
// Self-checking bench for the LED dimming control block.
// Assumes one 100 MHz clock; straps move in reset and once after capture to test the hold.
`timescale 1ns/10ps
module led_dimming_pwm_control_bench
    import ldp_pkg::*;
;
    localparam logic [2:0] MD [5] = '{3'h0, 3'h2, 3'h1, 3'h1, 3'h3};
    localparam logic [15:0] CL [5] = '{16'h1, 16'h1, 16'h1, 16'h3, 16'h1};
    localparam logic [15:0] BR [5] = '{16'h8000, 16'h8000, 16'h1000,
        16'h1000, 16'h8000};
    localparam logic [31:0] SC [5] = '{32'h10000, 32'h8000, 32'h2000,
        32'h1000, 32'h10000};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pwm_in = 1'b0;
    logic [STRAP_W-1:0] cfg_s = '0, frq_s = '0, mode_s = '0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, straps_ready;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
    logic [NUM_CH-1:0] led_pwm_out;
    logic [NUM_CH-1:0][CODE_W-1:0] lvl;
    logic [I2C_AW-1:0] i2c_address;
    logic [31:0] rise_t [NUM_CH], fall_t [NUM_CH];
    int err_total = 0, n_tests = 0;
    always #5 clk = ~clk;
    ldp_dimming_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .pwm_in(pwm_in),
        .string_config_strap(cfg_s), .pwm_frequency_strap(frq_s),
        .mode_strap(mode_s), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .led_pwm_out(led_pwm_out),
        .led_current_level(lvl), .i2c_address(i2c_address),
        .straps_ready(straps_ready));
    ldp_led_strings i_str (.clk(clk), .led_pwm_out(led_pwm_out),
        .rise_t(rise_t), .fall_t(fall_t));
    task automatic summarize();
        $display("Counts: %0d compared, %0d mismatched", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Tolerance absorbs the partial first pulse after reset
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g, int t = 0);
        n_tests++;
        if (!(g === e || (t > 0 && ^g !== 1'bx &&
              (g > e ? g - e : e - g) <= t))) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic tmo();
        err_total++;
        $display("MISMATCH wait expected event seen timeout");
        summarize();
    endtask
    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(logic [ADDR_W-1:0] a, logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %0h", a), e, reg_rvalid === 1'b1 ? reg_rdata : 'x);
    endtask
    task automatic run(logic [2:0] c, f, m, logic [15:0] ctl, b);
        sys_rst <= 1'b1;
        cfg_s <= c;
        frq_s <= f;
        mode_s <= m;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        if (ctl !== CTRL_RESET) begin
            wr(ADDR_CTRL, ctl);
            wr(ADDR_BRT, b);
        end
    endtask
    task automatic stat(logic [2:0] c, f, m);
        for (int i = 0; i < 20 && straps_ready !== 1'b1; i++) @(posedge clk);
        if (straps_ready !== 1'b1) tmo();
        rc(ADDR_STATUS, {22'h0, 1'b1, m, f, c});
        chk("i2c", m[2] ? I2C_ADDR_HIGH : I2C_ADDR_LOW, i2c_address);
    endtask
    task automatic rise(output logic [31:0] t);
        logic [31:0] old;
        int i;
        old = rise_t[0];
        for (i = 0; i < 6000 && rise_t[0] === old; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 6000) tmo();
        t = rise_t[0];
    endtask
    function automatic logic [31:0] off(int c);
        int deg [5] = '{60, 72, 90, 120, 180};
        return (c < 5) ? 32'(1024 * deg[c] / 360 * 5) : 32'h0;
    endfunction
    initial begin
        logic [31:0] t0, t1;
        int ch;
        logic [CODE_W-1:0] code;
        void'($urandom(32'h501C));
        run(3'h2, 3'h7, 3'h4, CTRL_RESET, BRT_RESET);
        for (int a = 0; a < 6; a++) rc(8'(a), 32'hFFF);
        rc(ADDR_CTRL, 32'h4);
        rc(ADDR_BRT, 32'h0);
        rc(8'h20, 32'h0);
        @(posedge clk);
        cfg_s <= 3'h7;
        mode_s <= 3'h0;
        repeat (4) @(posedge clk);
        stat(3'h2, 3'h7, 3'h4);
        $display("Test reset and straps done");
        for (int c = 0; c < 8; c++) begin
            run(3'(c), 3'h7, {c[0], 2'b00}, 16'h0001, 16'h8000);
            rise(t0);
            repeat (4600) @(posedge clk);
            chk("ch1 delay", off(c), rise_t[1] - t0, 10);
            chk("ch0 high", 32'd2560, fall_t[0] - t0, 10);
            stat(3'(c), 3'h7, {c[0], 2'b00});
            rise(t1);
            chk("period", 32'd5120, t1 - t0, 10);
        end
        $display("Test phase shift done");
        for (int k = 0; k < 5; k++) begin
            run(3'h0, 3'h7, MD[k], CL[k], BR[k]);
            ch = $urandom_range(5);
            code = 12'($urandom);
            wr(8'(ch), {4'h0, code});
            rc(8'(ch), {20'h0, code});
            repeat (20) @(posedge clk);
            chk("level", 32'(code) * SC[k] >> 16, 32'(lvl[ch]));
            if (k == 2) begin
                rise(t0);
                repeat (3000) @(posedge clk);
                chk("hyb high", 32'd2560, fall_t[0] - t0, 10);
            end
        end
        $display("Test current scale done");
        // Measured input duty through the default sloper, 16 of 64 high
        run(3'h2, 3'h7, 3'h2, CTRL_RESET, BRT_RESET);
        for (int k = 0; k < 192; k++) begin
            @(posedge clk);
            pwm_in <= (k % 64 < 16);
        end
        repeat (100) @(posedge clk);
        rc(ADDR_DUTY, 32'h4000);
        chk("slope lvl", 32'h3FF, 32'(lvl[0]));
        $display("Test measured duty done");
        run(3'h2, 3'h7, 3'h3, 16'h0001, 16'h0000);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            pwm_in <= 1'($urandom);
            repeat (4) @(posedge clk);
            #1;
            chk("direct", pwm_in ? 32'h0F : 32'h0, 32'(led_pwm_out));
        end
        $display("Test direct mode done");
        summarize();
    end
endmodule // led_dimming_pwm_control_bench
